// ### verilog/reset_recovery_sequencer.sv
// Overview of operation
// - drive pin on watchdog or clock failure
// - enter reset asynchronously on power-on, watchdog or clock fail, exit synchronously
// - four causes start a reset sequence
// - any cause pulls pin low, sequence
// - power-on or clock fail: 4096-cycle wait
// - drive pin low 16 to 17 cycles
// - sample pin nine cycles after release
// - low sample: external, clear latches, normal
// - high and clock failure: clock vector
// - high, no clock failure, watchdog: watchdog vector
`timescale 1ns/1ns
`default_nettype none
module reset_recovery_sequencer #(
  parameter logic [15:0] WATCHDOG_VECTOR = rst_seq_pkg::VEC_WATCHDOG_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic por_async,
  input wire logic watchdog_enable,
  input wire logic watchdog_timeout_source,
  input wire logic clkmon_enable,
  input wire logic clkmon_fail,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  output logic core_reset,
  output logic [15:0] reset_vector,
  output logic cause_external,
  output logic cause_clkmon,
  output logic cause_watchdog
);
  // state record: everything the sequencer holds except the cause latches
  typedef struct packed {
    rst_seq_pkg::seq_state_t state;
    logic [rst_seq_pkg::CNT_W-1:0] cnt;
    logic [15:0] vec;
    logic ext;
  } seq_regs_t;

  // record loaded on entry to reset: idle, pin driven, normal vector
  localparam seq_regs_t SEQ_RESET = '{
    state: rst_seq_pkg::ST_IDLE,
    cnt: '0,
    vec: rst_seq_pkg::VEC_NORMAL,
    ext: 1'b0
  };

  seq_regs_t cur;
  seq_regs_t next_cur;
  // clears the failure latches at the very edge that judges the cause
  // external, so the cause outputs agree with the vector from then on
  logic clr_causes;
  logic wdog_held; // latched watchdog timeout
  logic clk_held; // latched clock failure
  logic por_held; // power-on seen, wait pending
  logic wdog_set; // gated watchdog cause
  logic clk_set; // gated clock-monitor cause
  logic any_cause; // async entry request

  assign wdog_set = watchdog_enable & watchdog_timeout_source;
  assign clk_set = clkmon_enable & clkmon_fail;

  // failure latches, set without a clock
  // synchronous reset also clears the watchdog and clock latches, so they never start unknown
  cause_latch u_wdog (
    .sys_clk(sys_clk),
    .set_async(wdog_set),
    .clr(clr_causes | srst),
    .held(wdog_held)
  );
  cause_latch u_clk (
    .sys_clk(sys_clk),
    .set_async(clk_set),
    .clr(clr_causes | srst),
    .held(clk_held)
  );
  cause_latch u_por (
    .sys_clk(sys_clk),
    .set_async(por_async),
    .clr(cur.state == rst_seq_pkg::ST_DRIVE),
    .held(por_held)
  );

  // async entry: a power-on, watchdog or clock-fail cause forces the core into reset at once
  // srst is synchronous by design and is handled in the clocked branch
  assign any_cause = por_async | wdog_set | clk_set;

  // next-state logic
  always_comb begin
    next_cur = cur;
    clr_causes = 1'b0;
    unique case (cur.state)
      // waiting for oscillator, pin held low
      rst_seq_pkg::ST_OSC_WAIT: begin
        if (cur.cnt == rst_seq_pkg::CNT_W'(rst_seq_pkg::OSC_WAIT_CYCLES - 1)) begin
          next_cur.state = rst_seq_pkg::ST_DRIVE;
          next_cur.cnt = '0;
        end else begin
          next_cur.cnt = cur.cnt + 1'b1;
        end
      end
      // recovery drive, 16 cycles (17 with the entry edge)
      rst_seq_pkg::ST_DRIVE: begin
        if (cur.cnt == rst_seq_pkg::CNT_W'(rst_seq_pkg::DRIVE_MIN_CYCLES - 1)) begin
          next_cur.state = rst_seq_pkg::ST_SETTLE;
          next_cur.cnt = '0;
        end else begin
          next_cur.cnt = cur.cnt + 1'b1;
        end
      end
      // drive released; wait then sample
      rst_seq_pkg::ST_SETTLE: begin
        if (cur.cnt == rst_seq_pkg::CNT_W'(rst_seq_pkg::SAMPLE_DELAY_CYCLES - 1)) begin
          next_cur.state = rst_seq_pkg::ST_RUN;
          next_cur.cnt = '0;
          if (!reset_pin_in) begin
            next_cur.ext = 1'b1;
            clr_causes = 1'b1;
            next_cur.vec = rst_seq_pkg::VEC_NORMAL;
          end else if (clk_held) begin
            next_cur.ext = 1'b0;
            next_cur.vec = rst_seq_pkg::VEC_CLKMON;
          end else if (wdog_held) begin
            next_cur.ext = 1'b0;
            next_cur.vec = WATCHDOG_VECTOR;
          end else begin
            // no latched cause: treat as normal start
            next_cur.ext = 1'b0;
            next_cur.vec = rst_seq_pkg::VEC_NORMAL;
          end
        end else begin
          next_cur.cnt = cur.cnt + 1'b1;
        end
      end
      // running; a low pin level is an external cause
      rst_seq_pkg::ST_RUN: begin
        // external low on the pin restarts
        if (!reset_pin_in) begin
          next_cur.state = rst_seq_pkg::ST_DRIVE;
          next_cur.cnt = '0;
        end
      end
      // entered on every async or synchronous reset; picks wait or drive
      rst_seq_pkg::ST_IDLE: begin
        next_cur.cnt = '0;
        if (por_held || clk_held) begin
          // power-on or clock fail needs the wait
          next_cur.state = rst_seq_pkg::ST_OSC_WAIT;
        end else begin
          // other causes go straight to the recovery drive
          next_cur.state = rst_seq_pkg::ST_DRIVE;
        end
      end
      default: begin
        next_cur.state = rst_seq_pkg::ST_IDLE;
      end
    endcase
  end

  // state register; async entry picks wait or drive on the next clock
  always_ff @(posedge sys_clk or posedge any_cause) begin
    if (any_cause) begin
      // asynchronous entry to reset, constants only
      cur <= SEQ_RESET;
    end else if (srst) begin
      // synchronous reset lands in the same idle record
      cur <= SEQ_RESET;
    end else begin
      // exit from reset only ever advances on the clock
      cur <= next_cur;
    end
  end

  // pin driven low in wait, drive and idle states
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_n = !(cur.state == rst_seq_pkg::ST_OSC_WAIT ||
                            cur.state == rst_seq_pkg::ST_DRIVE ||
                            cur.state == rst_seq_pkg::ST_IDLE);
  assign core_reset = (cur.state != rst_seq_pkg::ST_RUN);
  assign reset_vector = cur.vec;
  assign cause_external = cur.ext;
  assign cause_clkmon = clk_held;
  assign cause_watchdog = wdog_held;
endmodule : reset_recovery_sequencer
`default_nettype wire

// ### verilog/rst_seq_pkg.sv
package rst_seq_pkg;
  // oscillator start-up wait, in cycles
  localparam int OSC_WAIT_CYCLES = 4096;
  // recovery drive length, lower and upper bound in cycles
  localparam int DRIVE_MIN_CYCLES = 16;
  localparam int DRIVE_MAX_CYCLES = 17;
  // delay from drive release to pin sample
  localparam int SAMPLE_DELAY_CYCLES = 9;
  // counter width, covers the largest count
  localparam int CNT_W = 13;
  // vector addresses (high word of pair)
  localparam logic [15:0] VEC_NORMAL = 16'hFFFE;
  localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
  // default watchdog vector, distinct from the other two
  localparam logic [15:0] VEC_WATCHDOG_DEFAULT = 16'hFFFA;
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_OSC_WAIT = 5'b0_0001,
    ST_DRIVE = 5'b0_0010,
    ST_SETTLE = 5'b0_0100,
    ST_RUN = 5'b0_1000,
    ST_IDLE = 5'b1_0000
  } seq_state_t;
endpackage : rst_seq_pkg

// ### verilog/cause_latch.sv
`timescale 1ns/1ns
`default_nettype none
// latches failure causes asynchronously so entry needs no clock
module cause_latch (
  input wire logic sys_clk,
  input wire logic set_async,
  input wire logic clr,
  output logic held
);
  // async set: held rises even with the clock stopped; sync clear
  always_ff @(posedge sys_clk or posedge set_async) begin
    if (set_async) begin
      held <= 1'b1;
    end else if (clr) begin
      held <= 1'b0;
    end
  end
endmodule : cause_latch
`default_nettype wire

// ### dv/rst_seq_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rst_seq_sva #(
  parameter logic [15:0] WATCHDOG_VECTOR = 16'h0000
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic por_async,
  input wire logic watchdog_enable,
  input wire logic watchdog_timeout_source,
  input wire logic clkmon_enable,
  input wire logic clkmon_fail,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic core_reset,
  input wire logic [15:0] reset_vector,
  input wire logic cause_external,
  input wire logic cause_clkmon,
  input wire logic cause_watchdog
);
  // low-drive length; a counter since the wait is far past repetition limits
  logic [13:0] low_cnt;
  always_ff @(posedge sys_clk) low_cnt <= (srst || reset_pin_oe_n) ? 14'h0000 : low_cnt + 14'h0001;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence rel; $rose(reset_pin_oe_n); endsequence
  sequence ext; $fell(core_reset); endsequence
  a_pin_low:
    assert property (!reset_pin_out) else $error("pin driven high");
  a_cause_entry:
    assert property ((watchdog_enable && watchdog_timeout_source) || por_async ||
      (clkmon_enable && clkmon_fail) |-> core_reset && !reset_pin_oe_n) else $error("no entry");
  a_pin_cause:
    assert property (!core_reset && !reset_pin_in |-> ##[0:1] core_reset) else $error("pin cause");
  a_drive_len:
    assert property (rel |-> low_cnt >= 14'd16) else $error("drive short");
  a_osc_wait:
    assert property (rel ##0 cause_clkmon |-> low_cnt >= 14'd4112) else $error("no wait");
  a_sample_hold:
    assert property (rel |-> core_reset [*8]) else $error("early exit");
  a_sample_exit:
    assert property (rel ##1 reset_pin_in [*8] |-> ##[0:2] !core_reset) else $error("late exit");
  a_ext_vector:
    assert property (ext ##0 cause_external |-> reset_vector == rst_seq_pkg::VEC_NORMAL &&
      !cause_clkmon && !cause_watchdog) else $error("external vector");
  a_clk_vector:
    assert property (ext ##0 cause_clkmon |-> reset_vector == rst_seq_pkg::VEC_CLKMON)
      else $error("clock vector");
  a_wd_vector:
    assert property (ext ##0 (!cause_clkmon && cause_watchdog) |-> reset_vector == WATCHDOG_VECTOR)
      else $error("watchdog vector");
  a_vec_stable:
    assert property (!core_reset && !$past(core_reset) |-> $stable(reset_vector))
      else $error("vector moved");
endmodule : rst_seq_sva
bind reset_recovery_sequencer rst_seq_sva #(.WATCHDOG_VECTOR(WATCHDOG_VECTOR)) sva_i (.*);
`default_nettype wire

// ### dv/ext_reset_circuit.sv
`timescale 1ns/1ns
`default_nettype none
module ext_reset_circuit (
  input wire logic sys_clk,
  input wire logic hold_low,
  input wire logic slow,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  output logic reset_pin_in
);
  logic [3:0] rise_cnt;
  logic drv;
  assign drv = !reset_pin_oe_n && !reset_pin_out;
  always_ff @(posedge sys_clk) rise_cnt <= drv ? 4'h0 : rise_cnt + {3'h0, rise_cnt != 4'hF};
  // pull-up rises at once, a heavy load takes twelve cycles
  assign reset_pin_in = !(hold_low || drv || (slow && rise_cnt < 4'hC));
endmodule : ext_reset_circuit
`default_nettype wire

// ### dv/reset_recovery_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module reset_recovery_sequencer_tb;
  localparam logic [15:0] WD_VEC = 16'hFFF8;
  logic sys_clk = 1'b0, srst = 1'b1, por_async = 1'b1, watchdog_enable = 1'b1;
  logic watchdog_timeout_source = 1'b0, clkmon_enable = 1'b0, clkmon_fail = 1'b0;
  logic hold_low = 1'b0, slow = 1'b0, reset_pin_in, reset_pin_out, reset_pin_oe_n;
  logic core_reset, cause_external, cause_clkmon, cause_watchdog;
  logic [15:0] reset_vector;
  int bad_count = 0, n_tests = 0, cyc;
  always #25 sys_clk = ~sys_clk;
  reset_recovery_sequencer #(.WATCHDOG_VECTOR(WD_VEC)) dut (.*);
  ext_reset_circuit far_end (.*);
  task automatic finish_test;
    $display("mismatches %0d checks %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h wanted %h", $time, got, exp);
    end
  endtask : chk
  // bounded wait for the core to leave reset
  task automatic wait_run;
    cyc = 0;
    while (core_reset !== 1'b0) begin
      @(negedge sys_clk);
      cyc++;
      if (cyc > 6000) begin
        bad_count++;
        finish_test();
      end
    end
  endtask : wait_run
  task automatic fire(ref logic s);
    @(negedge sys_clk) s = 1'b1;
    @(negedge sys_clk) s = 1'b0;
    wait_run();
  endtask : fire
  initial begin
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    por_async = 1'b0;
    wait_run();
    chk(16'(cyc >= 4112), 16'h0001);
    chk(reset_vector, rst_seq_pkg::VEC_NORMAL);
    fire(watchdog_timeout_source);
    chk(16'(cyc < 4096), 16'h0001);
    chk(reset_vector, WD_VEC);
    watchdog_enable = 1'b0;
    fire(watchdog_timeout_source);
    chk(16'(cyc), 16'h0000);
    clkmon_enable = 1'b1;
    fire(clkmon_fail);
    chk(16'(cyc >= 4096), 16'h0001);
    chk(reset_vector, rst_seq_pkg::VEC_CLKMON);
    watchdog_enable = 1'b1;
    slow = 1'b1;
    fire(watchdog_timeout_source);
    chk({13'h0000, cause_external, cause_clkmon, cause_watchdog}, 16'h0004);
    chk(reset_vector, rst_seq_pkg::VEC_NORMAL);
    slow = 1'b0;
    fire(hold_low);
    chk(16'(cyc > 16), 16'h0001);
    finish_test();
  end
endmodule : reset_recovery_sequencer_tb
`default_nettype wire
